// ---- eprom_prog_pkg.sv ----
package eprom_prog_pkg;

  localparam int          ADDR_W          = 16;           // processor address width
  localparam int          DATA_W          = 8;            // byte-wide memory
  localparam logic [15:0] EPROM_LIMIT     = 16'h8000;     // first address above the eprom region
  localparam int          CLK_HZ          = 40000000;     // core clock rate
  localparam int          PROG_TIME_US    = 5000;         // programming pulse, 5 ms
  localparam int          PROG_CYCLES_DEF = (PROG_TIME_US * (CLK_HZ / 1000000)); // whole cycles
  localparam int          CNT_W           = 18;           // holds 200000
  localparam logic [1:0]  SYNC_RESET      = 2'h0;         // synchroniser reset value

  // one-shot states
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_PULSE = 1'b1
  } shot_state_t;

endpackage : eprom_prog_pkg

// ---- eprom_program_wait_controller.sv ----
`timescale 1ns/1ps

module eprom_program_wait_controller
  import eprom_prog_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF  // shortenable for simulation
) (
  input  wire logic              core_clk_in,               // processor clock
  input  wire logic              rst_n_in,                  // async, active low
  input  wire logic [ADDR_W-1:0] addr_in,                   // processor address bus
  input  wire logic              mem_read_strobe_in,        // memory read cycle
  input  wire logic              memory_write_strobe_in,    // memory write strobe
  input  wire logic              program_verify_select_in,  // switch: 1 = program
  output logic                   eprom_select_out,          // eprom chip select
  output logic                   eprom_program_mode_out,    // eprom in program mode
  output logic                   wait_out,                  // processor wait request
  output logic                   vpp_enable_out,            // programming voltage gate
  output logic                   low_ram_disable_out        // keeps low ram page off the bus
);

  // whole state of the block
  typedef struct packed {
    logic [1:0]       wr_sync;    // write strobe synchroniser
    logic [1:0]       sel_sync;   // program switch synchroniser
    logic             wr_prev;    // strobe level last cycle
    shot_state_t      state;      // one-shot state
    logic [CNT_W-1:0] count;      // cycles left in pulse
    logic             eprom_sel;  // registered chip select
    logic             prog_mode;  // registered program mode
    logic             wait_req;   // registered wait request
    logic             vpp_en;     // registered voltage gate
    logic             ram_off;    // registered low ram disable
    logic [CNT_W:0]   wait_len;   // cycles wait has stood high, checks only
  } state_t;

  state_t cur;       // registered state
  state_t next_cur;  // next state

  // address test shared by read and write decode
  function automatic logic in_eprom(input logic [ADDR_W-1:0] a);
    in_eprom = (a < EPROM_LIMIT);
  endfunction : in_eprom

  // true in every cycle the one-shot runs
  function automatic logic pulsing(input shot_state_t s);
    pulsing = (s == ST_PULSE);
  endfunction : pulsing

  logic wr_rise;   // clean write strobe edge

  // next-state logic
  always_comb begin
    next_cur          = cur;
    // two flops on the strobe and switch, both outside the clock's timing
    next_cur.wr_sync  = {cur.wr_sync[0], memory_write_strobe_in};
    next_cur.sel_sync = {cur.sel_sync[0], program_verify_select_in};
    // edge taken from the settled flop only; the first may be metastable
    next_cur.wr_prev  = cur.wr_sync[1];
    wr_rise           = cur.wr_sync[1] & ~cur.wr_prev;
    // address and data are held by the processor during the wait
    unique case (cur.state)
      ST_IDLE: begin
        if (wr_rise && in_eprom(addr_in)) begin
          next_cur.state = ST_PULSE;
          next_cur.count = CNT_W'(PROG_CYCLES - 1);
        end
      end
      ST_PULSE: begin
        // strobes landing mid-pulse are dropped, not queued
        if (cur.count == '0) begin
          next_cur.state = ST_IDLE;
        end else begin
          next_cur.count = cur.count - CNT_W'(1);
        end
      end
    endcase
    // outputs follow the next state so they are flop-driven
    // wait and program mode share one state bit so they cannot part
    next_cur.wait_req  = pulsing(next_cur.state);
    next_cur.prog_mode = pulsing(next_cur.state);
    // switch read through its synchroniser, so a flip mid-pulse shows late
    next_cur.vpp_en    = pulsing(next_cur.state) & cur.sel_sync[1];
    // select during reads, and during program so the byte is latched
    next_cur.eprom_sel = in_eprom(addr_in) & (mem_read_strobe_in | pulsing(next_cur.state));
    // low ram stays off whenever the eprom region is addressed
    next_cur.ram_off   = in_eprom(addr_in);
    // length of the current wait, for the pulse checks only
    next_cur.wait_len  = cur.wait_req ? cur.wait_len + (CNT_W+1)'(1) : '0;
  end

  // state register; the reset branch loads constants only
  // one register for the whole block keeps every output a flop
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur          <= '0;
      cur.state    <= ST_IDLE;
      cur.wr_sync  <= SYNC_RESET;
      cur.sel_sync <= SYNC_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ports straight from the state flops
  assign eprom_select_out       = cur.eprom_sel;
  assign eprom_program_mode_out = cur.prog_mode;
  assign wait_out               = cur.wait_req;
  assign vpp_enable_out         = cur.vpp_en;
  assign low_ram_disable_out    = cur.ram_off;

  // checks on the flop outputs, all on the core clock
  // pulse start: wait comes one cycle after the qualified edge
  property p_start;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (cur.state == ST_IDLE && wr_rise && in_eprom(addr_in)) |=> wait_out;
  endproperty
  a_start: assert property (p_start) else $error("low write did not start wait");

  // no wait without a qualified low-region strobe
  property p_high_idle;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (!wait_out && !(wr_rise && in_eprom(addr_in))) |=> !wait_out;
  endproperty
  a_high_idle: assert property (p_high_idle) else $error("wait without low write");

  // pulse never outlasts the programming time
  property p_len_max;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      wait_out |-> (cur.wait_len < (CNT_W+1)'(PROG_CYCLES));
  endproperty
  a_len_max: assert property (p_len_max) else $error("pulse too long");

  // a released wait has stood exactly the programming time
  property p_len_min;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      $fell(wait_out) |-> ($past(cur.wait_len) == (CNT_W+1)'(PROG_CYCLES - 1));
  endproperty
  a_len_min: assert property (p_len_min) else $error("pulse wrong length");

  // pulse is not cut short while cycles remain
  property p_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (cur.state == ST_PULSE && cur.count != '0) |=> wait_out;
  endproperty
  a_hold: assert property (p_hold) else $error("pulse ended early");

  // program mode and wait stand together
  property p_mode_tracks;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      wait_out == eprom_program_mode_out;
  endproperty
  a_mode_tracks: assert property (p_mode_tracks) else $error("mode and wait differ");

  // voltage only inside a pulse with the switch on program
  property p_vpp;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      vpp_enable_out |-> (wait_out && $past(cur.sel_sync[1]));
  endproperty
  a_vpp: assert property (p_vpp) else $error("voltage outside program pulse");

  // and always there when both hold
  property p_vpp_on;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (wait_out && $past(cur.sel_sync[1])) |-> vpp_enable_out;
  endproperty
  a_vpp_on: assert property (p_vpp_on) else $error("voltage missing in program pulse");

  // low-region reads select the eprom
  property p_read_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (mem_read_strobe_in && in_eprom(addr_in)) |=> eprom_select_out;
  endproperty
  a_read_sel: assert property (p_read_sel) else $error("low read not selected");

  // addresses above the region never select it
  property p_read_high;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !in_eprom(addr_in) |=> !eprom_select_out;
  endproperty
  a_read_high: assert property (p_read_high) else $error("high address selected eprom");

  // eprom stays selected through a program pulse
  property p_sel_prog;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (wait_out && $past(in_eprom(addr_in))) |-> eprom_select_out;
  endproperty
  a_sel_prog: assert property (p_sel_prog) else $error("eprom not selected in pulse");

  // low ram page kept off in the eprom region
  property p_ram_off;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      in_eprom(addr_in) |=> low_ram_disable_out;
  endproperty
  a_ram_off: assert property (p_ram_off) else $error("low ram not disabled");

  // and left alone above it
  property p_ram_clear;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !in_eprom(addr_in) |=> !low_ram_disable_out;
  endproperty
  a_ram_clear: assert property (p_ram_clear) else $error("low ram disabled above region");

  // pulse end lets the processor go
  property p_release;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (cur.state == ST_PULSE && cur.count == '0) |=> (!wait_out && !eprom_program_mode_out);
  endproperty
  a_release: assert property (p_release) else $error("wait not released");

  c_program: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) $fell(wait_out) && $past(vpp_enable_out));
  c_verify:  cover property (@(posedge core_clk_in) disable iff (!rst_n_in) wait_out && !vpp_enable_out);
  c_read:    cover property (@(posedge core_clk_in) disable iff (!rst_n_in) eprom_select_out && !wait_out);
  // a strobe above the region that is refused
  c_refused: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) wr_rise && !in_eprom(addr_in));

endmodule : eprom_program_wait_controller

// ---- cpu_bus_model.sv ----
`timescale 1ns/1ps

module cpu_bus_model (
  input  wire logic        clk_in,   // processor clock
  input  wire logic        wait_in,  // stall request from controller
  output logic      [15:0] addr_out, // address bus
  output logic             rd_out,   // memory read cycle
  output logic             wr_out    // memory write strobe
);
  // idle bus at time zero
  initial begin
    addr_out = 16'hFFFF;
    rd_out   = 1'b0;
    wr_out   = 1'b0;
  end

  // one read cycle, then the bus is let go
  task automatic bus_read(input logic [15:0] a);
    addr_out = a;
    rd_out   = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out   = 1'b0;
    addr_out = ~a; // released bus never shows the old address
  endtask : bus_read

  // write strobe; stall as long as the controller asks, for at most 1000 cycles
  task automatic bus_write(input logic [15:0] a);
    int i;
    addr_out = a;
    wr_out   = 1'b1;
    for (i = 0; i < 8 && wait_in !== 1'b1; i++) begin // bounded wait for the stall
      @(posedge clk_in);
      #1;
    end
    for (i = 0; i < 1000 && wait_in === 1'b1; i++) begin // address and strobe held all through
      @(posedge clk_in);
      #1;
    end
    wr_out   = 1'b0;
    addr_out = ~a;
  endtask : bus_write
endmodule : cpu_bus_model

// ---- eprom_program_wait_controller_tb_top.sv ----
`timescale 1ns/1ps

module eprom_program_wait_controller_tb_top;
  import eprom_prog_pkg::*;
  localparam int PC = 20; // shortened pulse so the run stays short
  logic              clk, rst_n, sw, rd, wr, sel, pm, wt, vpp, ram_off;
  logic [ADDR_W-1:0] addr;          // processor address
  int                err_count       = 0;
  int                samples_checked = 0;
  int                n_w, n_p, n_v, n_s; // high-cycle tallies

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count cycles each pulse output stands high
  always @(posedge clk) begin
    n_w <= n_w + (wt === 1'b1 ? 1 : 0);
    n_p <= n_p + (pm === 1'b1 ? 1 : 0);
    n_v <= n_v + (vpp === 1'b1 ? 1 : 0);
    n_s <= n_s + (sel === 1'b1 ? 1 : 0);
  end

  cpu_bus_model u_cpu (.clk_in(clk), .wait_in(wt), .addr_out(addr), .rd_out(rd), .wr_out(wr));

  eprom_program_wait_controller #(.PROG_CYCLES(PC)) u_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .mem_read_strobe_in(rd),
    .memory_write_strobe_in(wr), .program_verify_select_in(sw), .eprom_select_out(sel),
    .eprom_program_mode_out(pm), .wait_out(wt), .vpp_enable_out(vpp), .low_ram_disable_out(ram_off));

  // read at a given address, judge decode outputs while they stand
  task automatic t_read(input logic [15:0] a, input logic exp);
    u_cpu.bus_read(a);
    samples_checked += 2;
    if (sel !== exp) begin
      err_count++;
      $display("Error %0t: eprom select on read", $time);
    end
    if (ram_off !== exp) begin
      err_count++;
      $display("Error %0t: low ram page disable", $time);
    end
    @(posedge clk); // read strobe idles one edge between reads
    #1;
  endtask : t_read

  // write with a switch setting, then judge the pulse windows
  task automatic t_write(input logic [15:0] a, input logic s);
    logic lo;
    int   w0, p0, v0, s0;
    lo = (a < EPROM_LIMIT);
    sw = s;
    repeat (4) @(posedge clk); // switch synchroniser settles, strobe low meanwhile
    #1;
    w0 = n_w;
    p0 = n_p;
    v0 = n_v;
    s0 = n_s;
    u_cpu.bus_write(a);
    repeat (3) @(posedge clk);
    #1;
    samples_checked += 5;
    if (n_w - w0 !== (lo ? PC : 0)) begin
      err_count++;
      $display("Error %0t: wait length", $time);
    end
    if (n_p - p0 !== (lo ? PC : 0)) begin
      err_count++;
      $display("Error %0t: program mode window", $time);
    end
    if (n_v - v0 !== ((lo && s) ? PC : 0)) begin
      err_count++;
      $display("Error %0t: voltage gate", $time);
    end
    if (n_s - s0 !== (lo ? PC : 0)) begin
      err_count++;
      $display("Error %0t: eprom select during pulse", $time);
    end
    if (wt !== 1'b0 || pm !== 1'b0) begin
      err_count++;
      $display("Error %0t: release after pulse", $time);
    end
  endtask : t_write

  // decode map: both ends of the region and the first address above
  task automatic scn_read_map;
    t_read(16'h0000, 1'b1);
    t_read(16'h7FFF, 1'b1);
    t_read(16'h8000, 1'b0);
  endtask : scn_read_map

  // program the top byte of the region, switch on program
  task automatic scn_program_top;
    t_write(16'h7FFF, 1'b1);
  endtask : scn_program_top

  // verify position: pulse runs, voltage stays off
  task automatic scn_verify_low;
    t_write(16'h0000, 1'b0);
  endtask : scn_verify_low

  // write above the region is refused
  task automatic scn_write_high;
    t_write(16'h8000, 1'b1);
  endtask : scn_write_high

  // a refused write leaves the next low write working
  task automatic scn_program_again;
    t_write(16'h0123, 1'b1);
  endtask : scn_program_again

  // verdict, the one place the run ends
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    rst_n = 1'b0;
    sw    = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    scn_read_map();
    scn_program_top();
    scn_verify_low();
    scn_write_high();
    scn_program_again();
    final_report();
  end

  // watchdog at 4000 cycles, far beyond the expected run of about 130 cycles
  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule : eprom_program_wait_controller_tb_top
